// *** hdl/bltl_transport.sv ***
// Boot link transport layer: session state machine, frame answers and AHB-Lite registers.
//
// How it works
// - The connect request's channel ID identifies the session in every frame.
// - Device answers with connect reply 0x02, length zero, nibble zero, same channel.
// - Host acknowledges the connect reply; the sequence nibble stays zero afterwards.
// - Device first acknowledges a valid disconnect request, echoing channel and nibble.
// - Device then sends disconnect reply 0x04 with the request's nibble.
// - Disconnect request and reply never advance the sequence nibble.
// - Host ack of the disconnect reply ends the session and requests device reset.
// - After reset, boot loader runs only if the entry stimulus is present.
// - In an open session every valid frame on the session channel except an ack is acknowledged with control 0x06, length zero.
// - An acknowledgement copies the channel and nibble of the acknowledged frame.
// - Outside the exceptions the nibble advances after each acknowledgement.
// - Header: sync 0xBEEFED, control, two-byte length, ID/nibble, checksum.
// - A connect request in idle gets no acknowledgement, only the connect reply; on the session channel in an open session it is acknowledged.
`timescale 1ns/1ps
module bltl_transport #(
  parameter logic CSUM_MODE = 1'b0,
  parameter int   CNT_W     = 16
) (
  // Clock, reset and enable
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ce,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Byte stream from the host
  input  wire logic                 rx_valid,
  input  wire bltl_pkg::bltl_byte_t rx_data,
  output logic                      rx_ready,
  // Byte stream to the host
  output logic                      tx_valid,
  output bltl_pkg::bltl_byte_t      tx_data,
  input  wire logic                 tx_ready,
  // Boot entry and reset request
  input  wire logic                 boot_stimulus,
  output logic                      boot_active,
  output logic                      sys_reset_req
);
  import bltl_pkg::*;

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must lie between 1 and 32");
  end

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_CONREP   = 4'b0001,
    ST_CONACK   = 4'b0010,
    ST_OPEN     = 4'b0011,
    ST_ACK      = 4'b0100,
    ST_DISCACK  = 4'b0101,
    ST_DISCREP  = 4'b0110,
    ST_DISCWAIT = 4'b0111
  } bltl_state_t;

  bltl_state_t      state;
  bltl_nib_t        chan;
  bltl_nib_t        cur_sqn;
  bltl_nib_t        ack_sqn;
  logic             frm_stb;
  logic             frm_ok;
  bltl_byte_t       frm_control;
  logic [15:0]      frm_length;
  bltl_nib_t        frm_chan;
  bltl_nib_t        frm_sqn;
  logic             tx_start;
  logic             tx_busy;
  bltl_byte_t       tx_control;
  bltl_nib_t        tx_sqn;
  logic [31:0]      ctrl;
  logic [CNT_W-1:0] good_frames;
  logic [CNT_W-1:0] drop_frames;
  logic             strap_taken;
  logic             good_own;
  logic             conreq_ok;
  logic             host_ack;
  logic             accepted;
  logic             wr_pend;
  logic [7:0]       wr_addr;

  bltl_rx_parser #(.CSUM_MODE(CSUM_MODE)) u_rx (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .rx_valid    (rx_valid),
    .rx_data     (rx_data),
    .rx_ready    (rx_ready),
    .frm_stb     (frm_stb),
    .frm_ok      (frm_ok),
    .frm_control (frm_control),
    .frm_length  (frm_length),
    .frm_chan    (frm_chan),
    .frm_sqn     (frm_sqn)
  );

  bltl_tx_framer #(.CSUM_MODE(CSUM_MODE)) u_tx (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .start    (tx_start),
    .control  (tx_control),
    .chan     (chan),
    .sqn      (tx_sqn),
    .busy     (tx_busy),
    .tx_valid (tx_valid),
    .tx_data  (tx_data),
    .tx_ready (tx_ready)
  );

  // Frame qualification: checksum good and, once a session exists, the session channel.
  assign good_own  = frm_stb && frm_ok && frm_chan == chan;
  assign conreq_ok = frm_stb && frm_ok && frm_control == CONNECT_REQUEST
                     && frm_length == ZERO_LENGTH && frm_sqn == SQN_START;
  assign host_ack  = good_own && frm_control == ACK_FRAME;

  // Outgoing frame selection; every frame carries the session channel.
  always_comb begin
    tx_control = ACK_FRAME;
    tx_sqn     = ack_sqn;
    tx_start   = 1'b0;
    case (state)
      ST_CONREP: begin
        tx_control = CONNECT_REPLY;
        tx_sqn     = SQN_START;
        tx_start   = !tx_busy;
      end
      ST_ACK, ST_DISCACK: begin
        tx_start = !tx_busy;
      end
      ST_DISCREP: begin
        tx_control = DISCONNECT_REPLY;
        tx_start   = !tx_busy;
      end
      default: begin
        tx_start = 1'b0;
      end
    endcase
  end

  // Entry stimulus is sampled once, after reset release, never by the reset itself.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_taken <= 1'b0;
      boot_active <= 1'b0;
    end else if (ce && !strap_taken) begin
      strap_taken <= 1'b1;
      boot_active <= boot_stimulus;
    end
  end

  // Session state machine.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= ST_IDLE;
      chan          <= 4'h0;
      cur_sqn       <= 4'h0;
      ack_sqn       <= 4'h0;
      sys_reset_req <= 1'b0;
    end else if (ce) begin
      sys_reset_req <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (conreq_ok && boot_active && ctrl[CTRL_ENABLE_BIT]) begin
            chan    <= frm_chan;
            cur_sqn <= SQN_START;
            state   <= ST_CONREP;
          end
        end
        ST_CONREP: begin
          if (!tx_busy) begin
            state <= ST_CONACK;
          end
        end
        ST_CONACK: begin
          if (host_ack && frm_sqn == SQN_START) begin
            state <= ST_OPEN;
          end
        end
        ST_OPEN: begin
          if (good_own && frm_control == DISCONNECT_REQUEST
              && frm_length == ZERO_LENGTH) begin
            ack_sqn <= frm_sqn;
            state   <= ST_DISCACK;
          end else if (good_own && frm_control != ACK_FRAME) begin
            ack_sqn <= frm_sqn;
            state   <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (!tx_busy) begin
            cur_sqn <= ack_sqn + 4'h1;
            state   <= ST_OPEN;
          end
        end
        ST_DISCACK: begin
          if (!tx_busy) begin
            state <= ST_DISCREP;
          end
        end
        ST_DISCREP: begin
          if (!tx_busy) begin
            state <= ST_DISCWAIT;
          end
        end
        ST_DISCWAIT: begin
          if (host_ack && frm_sqn == ack_sqn) begin
            sys_reset_req <= 1'b1;
            state         <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Frame counters: accepted frames versus those discarded or arriving while busy.
  always_comb begin
    case (state)
      ST_IDLE:     accepted = conreq_ok && boot_active && ctrl[CTRL_ENABLE_BIT];
      ST_CONACK:   accepted = host_ack && frm_sqn == SQN_START;
      ST_OPEN:     accepted = good_own;
      ST_DISCWAIT: accepted = host_ack && frm_sqn == ack_sqn;
      default:     accepted = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good_frames <= '0;
      drop_frames <= '0;
    end else if (ce && frm_stb) begin
      if (accepted) begin
        good_frames <= good_frames + 1'b1;
      end else begin
        drop_frames <= drop_frames + 1'b1;
      end
    end
  end

  // AHB-Lite slave with zero wait states; only the enable bit of CTRL is writable.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      ctrl    <= CTRL_RESET;
      hrdata  <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_pend && wr_addr == REG_CTRL) begin
        ctrl <= {31'h0000_0000, hwdata[CTRL_ENABLE_BIT]};
      end
      if (hready) begin
        wr_pend <= hsel && htrans[1] && hwrite && haddr[31:8] == 24'h00_0000;
        wr_addr <= haddr[7:0];
        hrdata  <= 32'h0000_0000;
        if (hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h00_0000) begin
          if (haddr[7:0] == REG_CTRL) begin
            hrdata <= ctrl;
          end else if (haddr[7:0] == REG_STATUS) begin
            hrdata <= 32'({tx_busy, boot_active, cur_sqn, chan, 4'(state)})
                      << ST_STATE_LSB;
          end else if (haddr[7:0] == REG_GOOD_FRAMES) begin
            hrdata <= 32'(good_frames);
          end else if (haddr[7:0] == REG_DROP_FRAMES) begin
            hrdata <= 32'(drop_frames);
          end
        end
      end else begin
        wr_pend <= wr_pend;
      end
    end
  end

  // Checks on the session behaviour.
  sequence s_disc_ack_sent;
    ce && state == ST_DISCACK && tx_start && tx_control == ACK_FRAME && tx_sqn == ack_sqn;
  endsequence

  sequence s_disconnect_reply_sent;
    ce && state == ST_DISCREP && tx_start && tx_control == DISCONNECT_REPLY
      && tx_sqn == ack_sqn;
  endsequence

  property p_conrep_fields;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_CONREP && tx_start) |-> (tx_control == CONNECT_REPLY && tx_sqn == 4'h0);
  endproperty
  a_conrep_fields: assert property (p_conrep_fields)
    else $error("connect reply fields wrong");

  property p_conreq_no_ack;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_IDLE && conreq_ok && boot_active && ctrl[0])
      |=> (state == ST_CONREP && chan == $past(frm_chan));
  endproperty
  a_conreq_no_ack: assert property (p_conreq_no_ack)
    else $error("connect request not answered by a connect reply");

  property p_conack_keeps_zero;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_CONACK && host_ack && frm_sqn == 4'h0)
      |=> (state == ST_OPEN && cur_sqn == 4'h0);
  endproperty
  a_conack_keeps_zero: assert property (p_conack_keeps_zero)
    else $error("sequence nibble moved after connect reply ack");

  property p_ack_advances;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_ACK && !tx_busy) |=> (cur_sqn == 4'($past(ack_sqn) + 4'h1));
  endproperty
  a_ack_advances: assert property (p_ack_advances)
    else $error("sequence nibble not advanced after ack");

  property p_disc_pair;
    @(posedge hclk) disable iff (!hresetn)
    s_disc_ack_sent |=> (state == ST_DISCREP && tx_busy);
  endproperty
  a_disc_pair: assert property (p_disc_pair)
    else $error("disconnect ack not followed by reply step");

  property p_disconnect_reply_nibble;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_DISCREP && tx_start) |-> s_disconnect_reply_sent;
  endproperty
  a_disconnect_reply_nibble: assert property (p_disconnect_reply_nibble)
    else $error("disconnect reply nibble differs from request");

  property p_disc_keeps_sqn;
    @(posedge hclk) disable iff (!hresetn)
    (state inside {ST_DISCACK, ST_DISCREP, ST_DISCWAIT}) |=> (cur_sqn == $past(cur_sqn));
  endproperty
  a_disc_keeps_sqn: assert property (p_disc_keeps_sqn)
    else $error("sequence nibble changed during disconnect");

  property p_reset_on_final_ack;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_DISCWAIT && host_ack && frm_sqn == ack_sqn)
      |=> (sys_reset_req && state == ST_IDLE) ##1 (!sys_reset_req || !$past(ce));
  endproperty
  a_reset_on_final_ack: assert property (p_reset_on_final_ack)
    else $error("no single reset request after final ack");

  property p_foreign_dropped;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state == ST_OPEN && frm_stb && frm_chan != chan) |=> (state == ST_OPEN);
  endproperty
  a_foreign_dropped: assert property (p_foreign_dropped)
    else $error("frame with foreign channel was answered");

endmodule : bltl_transport

// *** hdl/bltl_pkg.sv ***
// Shared constants, types and header checksum for the boot link transport layer.
package bltl_pkg;

  typedef logic [7:0] bltl_byte_t;
  typedef logic [3:0] bltl_nib_t;

  // Header layout: sync bytes 0..2, control byte 3, length 4..5, id/sqn 6, checksum 7.
  localparam logic [23:0] FRAME_SYNC_PATTERN = 24'hBE_EFED;
  localparam logic [2:0]  OFS_CONTROL_BYTE   = 3'h3;
  localparam logic [2:0]  OFS_LEN_HI         = 3'h4;
  localparam logic [2:0]  OFS_LEN_LO         = 3'h5;
  localparam logic [2:0]  OFS_ID_SQN         = 3'h6;
  localparam logic [2:0]  OFS_CHECKSUM       = 3'h7;
  localparam logic [2:0]  SYNC_BYTES         = 3'h3;

  // Control byte codes.
  localparam bltl_byte_t CONNECT_REQUEST    = 8'h01;
  localparam bltl_byte_t CONNECT_REPLY      = 8'h02;
  localparam bltl_byte_t DISCONNECT_REQUEST = 8'h03;
  localparam bltl_byte_t DISCONNECT_REPLY   = 8'h04;
  localparam bltl_byte_t ACK_FRAME          = 8'h06;
  localparam logic [15:0] ZERO_LENGTH       = 16'h0000;
  localparam bltl_nib_t  SQN_START          = 4'h0;

  // Register byte offsets and reset values.
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_GOOD_FRAMES = 8'h08;
  localparam logic [7:0]  REG_DROP_FRAMES = 8'h0C;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          ST_STATE_LSB    = 0;
  localparam int          ST_CHAN_LSB     = 4;
  localparam int          ST_SQN_LSB      = 8;
  localparam int          ST_BOOT_BIT     = 12;
  localparam int          ST_BUSY_BIT     = 13;

  // Checksum over header bytes 0..6; mode 0 is the negated byte sum, mode 1 the XOR.
  function automatic bltl_byte_t hdr_checksum(input logic [55:0] hdr, input logic mode);
    bltl_byte_t acc;
    acc = 8'h00;
    for (int i = 0; i < 7; i++) begin
      if (mode) begin
        acc = acc ^ hdr[55-8*i -: 8];
      end else begin
        acc = acc + hdr[55-8*i -: 8];
      end
    end
    return mode ? acc : 8'(8'h00 - acc);
  endfunction : hdr_checksum

endpackage : bltl_pkg

// *** hdl/bltl_rx_parser.sv ***
// Receive-side header parser: hunts sync, collects the header, skips any payload.
`timescale 1ns/1ps
module bltl_rx_parser #(
  parameter logic CSUM_MODE = 1'b0
) (
  // Clock, reset and enable
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  // Incoming byte stream
  input  wire logic                rx_valid,
  input  wire bltl_pkg::bltl_byte_t rx_data,
  output logic                     rx_ready,
  // Parsed frame, one-cycle strobe
  output logic                     frm_stb,
  output logic                     frm_ok,
  output bltl_pkg::bltl_byte_t     frm_control,
  output logic [15:0]              frm_length,
  output bltl_pkg::bltl_nib_t      frm_chan,
  output bltl_pkg::bltl_nib_t      frm_sqn
);
  import bltl_pkg::*;

  bltl_byte_t  hdr [0:6];
  logic [2:0]  idx;
  logic        in_body;
  logic [15:0] skip;
  logic [15:0] hdr_len;
  logic [55:0] hdr_flat;

  function automatic bltl_byte_t sync_byte(input logic [2:0] i);
    return FRAME_SYNC_PATTERN[23-8*i -: 8];
  endfunction : sync_byte

  // No buffer here: the parser takes a byte in every enabled cycle.
  assign rx_ready = ce;
  assign hdr_len  = {hdr[OFS_LEN_HI], hdr[OFS_LEN_LO]};
  assign hdr_flat = {hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5], hdr[6]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 7; i++) begin
        hdr[i] <= 8'h00;
      end
      idx         <= 3'h0;
      in_body     <= 1'b0;
      skip        <= 16'h0000;
      frm_stb     <= 1'b0;
      frm_ok      <= 1'b0;
      frm_control <= 8'h00;
      frm_length  <= 16'h0000;
      frm_chan    <= 4'h0;
      frm_sqn     <= 4'h0;
    end else if (ce) begin
      frm_stb <= 1'b0;
      if (rx_valid) begin
        if (in_body) begin
          skip <= skip - 16'h0001;
          if (skip == 16'h0001) begin
            in_body <= 1'b0;
            frm_stb <= 1'b1;
          end
        end else if (idx < SYNC_BYTES && rx_data != sync_byte(idx)) begin
          // A broken sync restarts the hunt; the byte may itself open a new frame.
          idx <= (rx_data == sync_byte(3'h0)) ? 3'h1 : 3'h0;
          if (rx_data == sync_byte(3'h0)) begin
            hdr[0] <= rx_data;
          end
        end else if (idx == OFS_CHECKSUM) begin
          idx         <= 3'h0;
          frm_control <= hdr[OFS_CONTROL_BYTE];
          frm_length  <= hdr_len;
          frm_chan    <= hdr[OFS_ID_SQN][7:4];
          frm_sqn     <= hdr[OFS_ID_SQN][3:0];
          frm_ok      <= (rx_data == hdr_checksum(hdr_flat, CSUM_MODE));
          if (hdr_len == ZERO_LENGTH) begin
            frm_stb <= 1'b1;
          end else begin
            in_body <= 1'b1;
            skip    <= hdr_len;
          end
        end else begin
          hdr[idx] <= rx_data;
          idx      <= idx + 3'h1;
        end
      end
    end
  end

endmodule : bltl_rx_parser

// *** hdl/bltl_tx_framer.sv ***
// Transmit-side framer: serialises one eight-byte header with its checksum.
`timescale 1ns/1ps
module bltl_tx_framer #(
  parameter logic CSUM_MODE = 1'b0
) (
  // Clock, reset and enable
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ce,
  // Frame request
  input  wire logic                 start,
  input  wire bltl_pkg::bltl_byte_t control,
  input  wire bltl_pkg::bltl_nib_t  chan,
  input  wire bltl_pkg::bltl_nib_t  sqn,
  output logic                      busy,
  // Outgoing byte stream
  output logic                      tx_valid,
  output bltl_pkg::bltl_byte_t      tx_data,
  input  wire logic                 tx_ready
);
  import bltl_pkg::*;

  bltl_byte_t  control_q;
  bltl_nib_t   chan_q;
  bltl_nib_t   sqn_q;
  logic [2:0]  pos;
  logic [55:0] hdr_bits;

  assign hdr_bits = {FRAME_SYNC_PATTERN, control_q, ZERO_LENGTH, chan_q, sqn_q};
  assign busy     = tx_valid;

  function automatic bltl_byte_t byte_at(input logic [55:0] h, input logic [2:0] p);
    return (p == OFS_CHECKSUM) ? hdr_checksum(h, CSUM_MODE) : h[55-8*p -: 8];
  endfunction : byte_at

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_q <= 8'h00;
      chan_q    <= 4'h0;
      sqn_q     <= 4'h0;
      pos       <= 3'h0;
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
    end else if (ce) begin
      if (start && !tx_valid) begin
        control_q <= control;
        chan_q    <= chan;
        sqn_q     <= sqn;
        pos       <= 3'h0;
        tx_valid  <= 1'b1;
        tx_data   <= FRAME_SYNC_PATTERN[23:16];
      end else if (tx_valid && tx_ready) begin
        if (pos == OFS_CHECKSUM) begin
          tx_valid <= 1'b0;
        end else begin
          pos     <= pos + 3'h1;
          tx_data <= byte_at(hdr_bits, pos + 3'h1);
        end
      end
    end
  end

  property p_first_byte_sync;
    @(posedge hclk) disable iff (!hresetn)
    (ce && start && !tx_valid) |=> (tx_valid && tx_data == FRAME_SYNC_PATTERN[23:16]);
  endproperty
  a_first_byte_sync: assert property (p_first_byte_sync)
    else $error("frame did not open with the first sync byte");

endmodule : bltl_tx_framer

// *** verification/bltl_host_model.sv ***
// Host model for the boot link: sends frames and collects the device's answers.
`timescale 1ns/1ps
module bltl_host_model (
  // Clock and pacing
  input  wire logic                 hclk,
  input  wire logic                 slow,
  // Bytes towards the device
  output logic                      rx_valid,
  output bltl_pkg::bltl_byte_t      rx_data,
  // Bytes from the device
  input  wire logic                 tx_valid,
  input  wire bltl_pkg::bltl_byte_t tx_data,
  output logic                      tx_ready
);
  import bltl_pkg::*;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end
  // A slow host stalls every other cycle, so the device must hold each byte.
  always @(posedge hclk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  function automatic logic [63:0] mk(input bltl_byte_t c, input bltl_nib_t h, input bltl_nib_t q);
    logic [55:0] hd;
    bltl_byte_t  s;
    hd = {24'hBE_EFED, c, 16'h0000, h, q};
    s  = 8'h00;
    for (int i = 0; i < 7; i++) begin
      s = s - hd[8*i +: 8];
    end
    return {hd, s};
  endfunction : mk
  task automatic send(input logic [63:0] f);
    for (int i = 7; i >= 0; i--) begin
      rx_valid <= 1'b1;
      rx_data  <= f[8*i +: 8];
      @(posedge hclk);
    end
    rx_valid <= 1'b0;
    // A released line must not keep showing the last byte.
    rx_data  <= ~f[7:0];
  endtask : send
  task automatic get(output logic [63:0] f);
    int n;
    int t;
    n = 0;
    t = 0;
    f = '0;
    while (n < 8 && t < 200) begin
      @(posedge hclk);
      t++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        f = {f[55:0], tx_data};
        n++;
      end
    end
  endtask : get
endmodule : bltl_host_model

// *** verification/tb.sv ***
// Self-checking bench for the boot link transport layer against a host model.
`timescale 1ns/1ps
module tb;
  import bltl_pkg::*;
  typedef struct {
    bltl_byte_t c;
    bltl_nib_t  h;
    bltl_nib_t  q;
    logic       b;
    int         n;
    bltl_byte_t r0;
    bltl_byte_t r1;
  } bltl_row_t;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, rx_valid, rx_ready;
  logic        tx_valid, tx_ready, boot_stimulus, boot_active, sys_reset_req, slow, ce;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [63:0] g;
  bltl_byte_t  rx_data, tx_data;
  int          err_count, num_checks, cycles;
  bltl_row_t   rows[7] = '{
    '{CONNECT_REQUEST, 4'h5, 4'h0, 1'b0, 1, CONNECT_REPLY, 8'h00},
    '{ACK_FRAME, 4'h5, 4'h0, 1'b0, 0, 8'h00, 8'h00},
    '{8'h05, 4'h5, 4'h0, 1'b0, 1, ACK_FRAME, 8'h00},
    '{8'h05, 4'h5, 4'h1, 1'b1, 0, 8'h00, 8'h00},
    '{8'h05, 4'h9, 4'h1, 1'b0, 0, 8'h00, 8'h00},
    '{8'h05, 4'h5, 4'h1, 1'b0, 1, ACK_FRAME, 8'h00},
    '{DISCONNECT_REQUEST, 4'h5, 4'h2, 1'b0, 2, ACK_FRAME, DISCONNECT_REPLY}
  };

  bltl_transport u_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .boot_stimulus(boot_stimulus), .boot_active(boot_active),
    .sys_reset_req(sys_reset_req));
  bltl_host_model u_host (
    .hclk(hclk), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb
  // Thirty idle cycles is well past the two-edge reply latency of the framer.
  task automatic quiet();
    logic s;
    s = 1'b0;
    repeat (30) begin
      @(posedge hclk);
      s = s | (tx_valid !== 1'b0);
    end
    chk(s, 1'b0);
  endtask : quiet
  task automatic rst();
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : rst
  task results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata} = '0;
    boot_stimulus = 1'b1;
    slow = 1'b0;
    ce = 1'b1;
    err_count = 0;
    num_checks = 0;
    cycles = 0;
    rst();
    chk(boot_active, 1'b1);
    ahb(1'b0, 32'(REG_CTRL), 32'h0000_0000);
    chk(r, CTRL_RESET);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    ahb(1'b1, 32'(REG_CTRL), 32'h0000_0000);
    u_host.send(u_host.mk(CONNECT_REQUEST, 4'h5, 4'h0));
    quiet();
    ahb(1'b1, 32'(REG_CTRL), 32'h0000_0001);
    for (int i = 0; i < 7; i++) begin
      slow <= (i == 6);
      // A bad row flips the checksum's low bit.
      u_host.send(u_host.mk(rows[i].c, rows[i].h, rows[i].q) ^ 64'(rows[i].b));
      if (rows[i].n > 0) begin
        u_host.get(g);
        chk(g, u_host.mk(rows[i].r0, 4'h5, rows[i].q));
      end
      if (rows[i].n > 1) begin
        u_host.get(g);
        chk(g, u_host.mk(rows[i].r1, 4'h5, rows[i].q));
      end
      quiet();
    end
    ahb(1'b0, 32'(REG_STATUS), 32'h0000_0000);
    chk(r, 32'h0000_1257);
    ahb(1'b0, 32'(REG_GOOD_FRAMES), 32'h0000_0000);
    chk(r, 32'h0000_0005);
    ahb(1'b0, 32'(REG_DROP_FRAMES), 32'h0000_0000);
    chk(r, 32'h0000_0003);
    // A frozen block must ignore the final ack; it is sent again once running.
    ce <= 1'b0;
    u_host.send(u_host.mk(ACK_FRAME, 4'h5, 4'h2));
    repeat (2) @(posedge hclk);
    chk(rx_ready, 1'b0);
    chk(sys_reset_req, 1'b0);
    ce <= 1'b1;
    u_host.send(u_host.mk(ACK_FRAME, 4'h5, 4'h2));
    g = '0;
    repeat (20) begin
      @(posedge hclk);
      g[0] = g[0] | (sys_reset_req === 1'b1);
    end
    chk(g, 64'h1);
    boot_stimulus <= 1'b0;
    rst();
    chk(boot_active, 1'b0);
    u_host.send(u_host.mk(CONNECT_REQUEST, 4'h5, 4'h0));
    quiet();
    results();
  end
endmodule : tb
